// ---- verilog/oscsc_top.sv ----
// Register access over Avalon-MM and the placing of the registers were decided locally.
`default_nettype none
module oscsc_top
    import oscsc_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // Avalon-MM slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Access guard and debug
    input  wire logic        write_protect,
    input  wire logic        debug_halt,
    input  wire logic        ext_debug_access,
    input  wire logic        debug_cold_plug,
    // Power manager
    input  wire logic [1:0]  sleep_mode,
    input  wire logic        clk_request,
    input  wire logic        brownout_event,
    output logic             brownout_reset_en,
    output logic             irq,
    // Oscillator analog side
    output logic             osc_run,
    output logic             osc_xtal_mode,
    output logic [2:0]       osc_gain,
    output logic             osc_auto_amp,
    output logic             osc_clk_gate,
    output logic             ulp_run,
    // Pin ownership
    output logic             osc_input_pin_own,
    output logic             osc_output_pin_own
);
    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [1:0] slp_s;
    logic       req_s;
    logic       bod_s;
    logic       halt_s;
    logic       cold_s;
    oscsc_sync #(.W(6)) u_sync (
        .clk   (clk),
        .reset (reset),
        .d     ({sleep_mode, clk_request, brownout_event, debug_halt, debug_cold_plug}),
        .q     ({slp_s, req_s, bod_s, halt_s, cold_s})
    );

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [15:0] xctrl_q;
    logic [1:0]  inten_q;
    logic [1:0]  flag_q;
    logic        bod_act_q;
    logic        ack_q;
    logic        ready;
    logic        ready_q;
    logic        run_d;

    // Write is allowed when unguarded or debug overrides guard
    function automatic logic wr_ok(input logic prot, input logic halt,
                                   input logic ext);
        wr_ok = !prot || halt || ext;
    endfunction

    logic acc;
    logic wr;
    logic wr_prot;
    assign acc = (avs_read || avs_write) && !ack_q;
    assign wr  = avs_write && !ack_q;
    // Interrupt flag register is never guarded
    assign wr_prot = wr && wr_ok(write_protect, halt_s, ext_debug_access);

    // One wait cycle per access; answer the second edge
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= acc;
        end
    end
    // Held high while idle, so a new request waits with no logic on the path
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !acc;
        end
    end

    // Crystal control register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            xctrl_q <= OSCSC_XCTRL_RST;
        end else if (wr_prot && avs_address == OSCSC_XCTRL_OFS) begin
            xctrl_q <= avs_writedata[15:0] & OSCSC_XCTRL_MSK;
        end
    end

    // Interrupt enable set and clear registers
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            inten_q <= '0;
        end else if (wr_prot && avs_address == OSCSC_IRQ_EN_SET_OFS) begin
            inten_q <= inten_q | avs_writedata[1:0];
        end else if (wr_prot && avs_address == OSCSC_IRQ_EN_CLR_OFS) begin
            inten_q <= inten_q & ~avs_writedata[1:0];
        end
    end

    // Brownout reset enable, guarded
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            bod_act_q <= 1'b1;
        end else if (wr_prot && avs_address == OSCSC_BODCTRL_OFS) begin
            bod_act_q <= avs_writedata[0];
        end
    end

    // ------------------------------------------------------------
    // Run decision; unaffected by debug halt
    // ------------------------------------------------------------
    logic en;
    logic ondem;
    logic stdby;
    assign en    = xctrl_q[OSCSC_ENABLE_BIT];
    assign ondem = xctrl_q[OSCSC_ONDEM_BIT];
    assign stdby = xctrl_q[OSCSC_STDBY_BIT];
    always_comb begin
        run_d = 1'b0;
        if (en) begin
            case (slp_s)
                OSCSC_SLP_IDLE:  run_d = !ondem || req_s;
                OSCSC_SLP_STDBY: run_d = stdby && (!ondem || req_s);
                default:         run_d = 1'b1;
            endcase
        end
    end

    oscsc_startup u_start (
        .clk   (clk),
        .reset (reset),
        .run   (run_d),
        .sel   (xctrl_q[OSCSC_STARTUP_LSB +: 4]),
        .ready (ready)
    );

    // Status flags: set beats software clear
    logic [1:0] ev;
    assign ev = {bod_s, ready && !ready_q};
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ready_q <= 1'b0;
            flag_q  <= '0;
        end else begin
            ready_q <= ready;
            if (wr && avs_address == OSCSC_IRQ_FLAG_OFS) begin
                flag_q <= (flag_q & ~avs_writedata[1:0]) | ev;
            end else begin
                flag_q <= flag_q | ev;
            end
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            avs_readdata <= '0;
        end else if (avs_read && !ack_q) begin
            case (avs_address)
                OSCSC_IRQ_EN_CLR_OFS,
                OSCSC_IRQ_EN_SET_OFS: avs_readdata <= {30'h0, inten_q};
                OSCSC_IRQ_FLAG_OFS:   avs_readdata <= {30'h0, flag_q};
                OSCSC_STATUS_OFS:   avs_readdata <= {30'h0, bod_s, ready};
                OSCSC_XCTRL_OFS:    avs_readdata <= {16'h0, xctrl_q};
                OSCSC_ULPCTRL_OFS:  avs_readdata <= 32'h0000_0001;
                OSCSC_BODCTRL_OFS:  avs_readdata <= {31'h0, bod_act_q};
                default:            avs_readdata <= OSCSC_UNMAPPED_RD;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Outputs from flops
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            osc_run            <= 1'b0;
            osc_xtal_mode      <= 1'b0;
            osc_gain           <= '0;
            osc_auto_amp       <= 1'b0;
            osc_clk_gate       <= 1'b0;
            osc_input_pin_own  <= 1'b0;
            osc_output_pin_own <= 1'b0;
            ulp_run            <= 1'b1;
            irq                <= 1'b0;
            brownout_reset_en  <= 1'b1;
        end else begin
            osc_run            <= run_d;
            osc_xtal_mode      <= xctrl_q[OSCSC_XTAL_BIT];
            osc_gain           <= xctrl_q[OSCSC_GAIN_LSB +: 3];
            osc_auto_amp       <= xctrl_q[OSCSC_AMP_BIT];
            osc_clk_gate       <= run_d && ready;
            osc_input_pin_own  <= en;
            osc_output_pin_own <= en && xctrl_q[OSCSC_XTAL_BIT];
            ulp_run            <= 1'b1;
            irq                <= |(flag_q & inten_q);
            brownout_reset_en  <= bod_act_q && !cold_s;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    gate_needs_ready_a: assert property (@(posedge clk) disable iff (reset)
        osc_clk_gate |-> $past(ready)) else $error("clock passed before ready");
    pin_mode_a: assert property (@(posedge clk) disable iff (reset)
        osc_output_pin_own |-> osc_input_pin_own) else $error("pin owner mismatch");
    stdby_stop_a: assert property (@(posedge clk) disable iff (reset)
        (slp_s == OSCSC_SLP_STDBY && !stdby) |=> !osc_run) else $error("ran in standby");
    idle_force_a: assert property (@(posedge clk) disable iff (reset)
        (slp_s == OSCSC_SLP_IDLE && en && !ondem) |=> osc_run) else $error("idle stop");
    ready_irq_a: assert property (@(posedge clk) disable iff (reset)
        ($rose(ready) && inten_q[0]) |=> ##1 irq) else $error("no ready irq");
    stop_clears_a: assert property (@(posedge clk) disable iff (reset)
        !run_d |=> !ready) else $error("ready while stopped");
    ulp_always_a: assert property (@(posedge clk) disable iff (reset)
        ulp_run) else $error("ulp stopped");
    cold_mask_a: assert property (@(posedge clk) disable iff (reset)
        cold_s |=> !brownout_reset_en) else $error("bod reset not masked");
    guard_block_a: assert property (@(posedge clk) disable iff (reset)
        (wr && write_protect && !halt_s && !ext_debug_access
         && avs_address == OSCSC_XCTRL_OFS) |=> $stable(xctrl_q))
        else $error("protected write landed");
    cov_ready_c: cover property (@(posedge clk) disable iff (reset) $rose(ready));
    cov_stdby_c: cover property (@(posedge clk) disable iff (reset)
        slp_s == OSCSC_SLP_STDBY && osc_run);
    cov_irq_c: cover property (@(posedge clk) disable iff (reset) $rose(irq));
endmodule
`default_nettype wire

// ---- pkg/oscsc_pkg.sv ----
// Contract
// - Debug halt leaves oscillator control running
// - Cold-plug debugger masks 3.3V brownout reset
// - Writable registers protectable except interrupt flags
// - Debug halt disables all write protection
// - External debugger writes bypass protection
// - Status register gathers sub-unit status, interrupts
// - Enable bit starts and stops oscillator
// - Default: idle on request, standby stop
// - Ultra-low-power 32k oscillator always runs
// - Run-on-request resets one; zero runs idle
// - Standby run follows keep and request bits
// - Crystal oscillator disabled after reset, pins free
// - Crystal mode takes both pins, external one
// - Crystal-select one crystal, zero external clock
// - Auto amplitude control bit adjusts amplitude
// - Keep one, request zero: always runs
// - Start-up delay after reset or wake-off
// - Output masked during start-up period
// - Ready flag set when start-up elapses
// - Interrupt on ready rise when enabled
// - Separate enable set, clear, flag registers
`default_nettype none
package oscsc_pkg;
    // ------------------------------------------------------------
    // Register word offsets
    // ------------------------------------------------------------
    localparam logic [3:0] OSCSC_IRQ_EN_CLR_OFS = 4'h0;
    localparam logic [3:0] OSCSC_IRQ_EN_SET_OFS = 4'h1;
    localparam logic [3:0] OSCSC_IRQ_FLAG_OFS   = 4'h2;
    localparam logic [3:0] OSCSC_STATUS_OFS     = 4'h3;
    localparam logic [3:0] OSCSC_XCTRL_OFS      = 4'h4;
    localparam logic [3:0] OSCSC_ULPCTRL_OFS    = 4'h5;
    localparam logic [3:0] OSCSC_BODCTRL_OFS    = 4'h6;
    // ------------------------------------------------------------
    // Crystal control fields
    // ------------------------------------------------------------
    localparam int OSCSC_ENABLE_BIT  = 1;
    localparam int OSCSC_XTAL_BIT    = 2;
    localparam int OSCSC_STDBY_BIT   = 6;
    localparam int OSCSC_ONDEM_BIT   = 7;
    localparam int OSCSC_GAIN_LSB    = 8;
    localparam int OSCSC_AMP_BIT     = 11;
    localparam int OSCSC_STARTUP_LSB = 12;
    localparam logic [15:0] OSCSC_XCTRL_RST = 16'h0080;
    localparam logic [15:0] OSCSC_XCTRL_MSK = 16'hffc6;
    // Status / flag bit positions
    localparam int OSCSC_XRDY_BIT = 0;
    localparam int OSCSC_BODDET_BIT = 1;
    localparam logic [1:0] OSCSC_IRQ_MSK = 2'h3;
    // Sleep mode encoding
    localparam logic [1:0] OSCSC_SLP_ACTIVE = 2'h0;
    localparam logic [1:0] OSCSC_SLP_IDLE   = 2'h1;
    localparam logic [1:0] OSCSC_SLP_STDBY  = 2'h2;
    // Start-up base count, shortened in cycles per step
    localparam int OSCSC_STARTUP_BASE = 1;
    // Unmapped address read answer
    localparam logic [31:0] OSCSC_UNMAPPED_RD = 32'h0000_0000;
endpackage
`default_nettype wire

// ---- verilog/oscsc_sync.sv ----
`default_nettype none
module oscsc_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         reset,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    // ------------------------------------------------------------
    // Two-stage synchroniser
    // ------------------------------------------------------------
    logic [W-1:0] meta_q;
    // First stage read only by the second
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ---- verilog/oscsc_startup.sv ----
`default_nettype none
module oscsc_startup
    import oscsc_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // Control
    input  wire logic       run,
    input  wire logic [3:0] sel,
    // Status
    output logic            ready
);
    // ------------------------------------------------------------
    // Start-up counter: 2^sel steps of base
    // ------------------------------------------------------------
    logic [16:0] cnt_q;
    logic [16:0] lim;
    assign lim = 17'(OSCSC_STARTUP_BASE) << sel;
    // Restart whenever oscillator stops, so each start waits again
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cnt_q <= '0;
            ready <= 1'b0;
        end else if (!run) begin
            cnt_q <= '0;
            ready <= 1'b0;
        end else if (!ready) begin
            if (cnt_q + 17'h1 >= lim) begin
                ready <= 1'b1;
            end
            cnt_q <= cnt_q + 17'h1;
        end
    end
    starts_not_ready_a: assert property (@(posedge clk) disable iff (reset)
        $rose(run) |-> !ready) else $error("ready without start-up");
endmodule
`default_nettype wire

// ---- verif/oscsc_xtal_model.sv ----
`default_nettype none
module oscsc_xtal_model (
    // Drive from the block
    input  wire logic run,
    input  wire logic xtal_mode,
    // Clock from the pin side
    output logic      xclk
);
    timeunit 1ns;
    timeprecision 1ns;
    // Rings only while driven, otherwise stands still; the two modes get
    // different rates so a wrong mode shows as a different period
    initial begin
        xclk = 1'b0;
        forever begin
            #(xtal_mode ? 31 : 23);
            if (run === 1'b1) xclk = ~xclk;
        end
    end
endmodule
`default_nettype wire

// ---- verif/oscsc_top_tb.sv ----
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module oscsc_top_tb
    import oscsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------
    // Bench signals
    // ------------------------------------------------------------
    logic        clk, reset, rd, wr, wp, dh, xd, cp, req, bev;
    logic [3:0]  adr;
    logic [31:0] wd, rv;
    logic [1:0]  slp;
    wire logic [31:0] rdata;
    wire logic [2:0]  gain;
    wire logic        wreq, bre, irq, run, xm, aa, gate, ulp, pin_i, pin_o, xclk;
    int          error_cnt, n_compared;
    int          xedges;
    // Counts pin-side clock changes, to see the model ring or stand
    always @(xclk) xedges++;

    oscsc_top oscsc_top_i (.clk(clk), .reset(reset), .avs_address(adr), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wd), .avs_readdata(rdata), .avs_waitrequest(wreq),
        .write_protect(wp), .debug_halt(dh), .ext_debug_access(xd), .debug_cold_plug(cp),
        .sleep_mode(slp), .clk_request(req), .brownout_event(bev), .brownout_reset_en(bre),
        .irq(irq), .osc_run(run), .osc_xtal_mode(xm), .osc_gain(gain), .osc_auto_amp(aa),
        .osc_clk_gate(gate), .ulp_run(ulp), .osc_input_pin_own(pin_i),
        .osc_output_pin_own(pin_o));
    oscsc_xtal_model oscsc_xtal_model_i (.run(run), .xtal_mode(xm), .xclk(xclk));

    // Free-running bus clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // One bus cycle; an idle edge follows so the next request starts clean
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int k;
        rd <= !w; wr <= w; adr <= a; wd <= d;
        for (k = 0; k < 20; k++) begin
            @(posedge clk);
            if (wreq === 1'b0) break;
        end
        if (k == 20) begin
            error_cnt++;
            test_done();
        end
        rv = rdata;
        rd <= 1'b0; wr <= 1'b0;
        @(posedge clk);
    endtask
    function automatic logic [31:0] xc(logic en, x, k, o, logic [2:0] g, logic a,
                                       logic [3:0] s);
        return {16'h0, s, a, g, o, k, 3'h0, x, en, 1'b0};
    endfunction
    // Cycles until the gated clock opens, bounded
    task automatic wait_gate(output int n);
        for (n = 0; n < 60 && gate !== 1'b1; n++) @(posedge clk);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        bus(0, OSCSC_XCTRL_OFS, 0);
        `CHK("xctrl", 32'h0000_0080, rv)
        `CHK("pins", 3'h0, {run, pin_i, pin_o})
        bus(1, OSCSC_ULPCTRL_OFS, 0);
        bus(0, OSCSC_ULPCTRL_OFS, 0);
        `CHK("ulp", 3'h7, {rv[0], ulp, bre})
        bus(0, 4'hc, 0);
        `CHK("unmapped", OSCSC_UNMAPPED_RD, rv)
        $display("t_reset done");
    endtask
    task automatic t_modes();
        logic k, o, q, s, x, e;
        for (int i = 0; i < 16; i++) begin
            {s, q, o, k} = 4'(i);
            x = k ^ o;
            slp <= OSCSC_SLP_ACTIVE;
            bus(1, OSCSC_XCTRL_OFS, xc(1, x, k, o, 3'(i), s, 4'h0));
            cyc(4); // Start-up over before any standby entry
            `CHK("active", 1'b1, run)
            req <= q;
            slp <= s ? OSCSC_SLP_STDBY : OSCSC_SLP_IDLE;
            cyc(6);
            e = s ? (k & (!o | q)) : (!o | q);
            `CHK("run", e, run)
            `CHK("pins", {1'b1, x}, {pin_i, pin_o})
            `CHK("mode", {x, 3'(i), s}, {xm, gain, aa})
        end
        slp <= OSCSC_SLP_ACTIVE;
        bus(1, OSCSC_XCTRL_OFS, xc(0, 1, 0, 1, 3'h0, 0, 4'h0));
        cyc(3);
        `CHK("off", 3'h0, {run, pin_i, pin_o})
        $display("t_modes done");
    endtask
    task automatic t_startup();
        int n;
        bus(1, OSCSC_IRQ_FLAG_OFS, 32'h3);
        bus(1, OSCSC_IRQ_EN_SET_OFS, 32'h1);
        bus(1, OSCSC_XCTRL_OFS, xc(1, 1, 0, 0, 3'h0, 0, 4'h3));
        wait_gate(n);
        `CHK("startup", 1'b1, n >= 6 && n <= 12)
        bus(0, OSCSC_STATUS_OFS, 0);
        `CHK("ready", 2'h3, {rv[0], irq})
        bus(1, OSCSC_IRQ_EN_CLR_OFS, 32'h1);
        `CHK("masked", 1'b0, irq)
        bus(1, OSCSC_IRQ_EN_SET_OFS, 32'h1);
        `CHK("unmasked", 1'b1, irq)
        bus(1, OSCSC_IRQ_FLAG_OFS, 32'h1);
        `CHK("cleared", 1'b0, irq)
        slp <= OSCSC_SLP_STDBY;
        cyc(6);
        bus(0, OSCSC_STATUS_OFS, 0);
        `CHK("sleep", 3'h0, {rv[0], gate, run})
        xedges = 0;
        cyc(4);
        `CHK("xstill", 0, xedges)
        slp <= OSCSC_SLP_ACTIVE;
        wait_gate(n);
        `CHK("wake", 1'b1, n >= 8 && n <= 14)
        cyc(2);
        `CHK("reirq", 1'b1, irq)
        // Crystal rate: 100 ns window holds three or four half periods
        xedges = 0;
        cyc(10);
        `CHK("xclk", 1'b1, xedges >= 3 && xedges <= 4)
        $display("t_startup done");
    endtask
    task automatic t_protect();
        wp <= 1'b1;
        bev <= 1'b1;
        bus(1, OSCSC_XCTRL_OFS, 0);
        bus(0, OSCSC_XCTRL_OFS, 0);
        `CHK("guarded", 32'h0000_3006, rv)
        bus(0, OSCSC_STATUS_OFS, 0);
        `CHK("bodstat", 1'b1, rv[1])
        bev <= 1'b0;
        cyc(3); // Synchronised level must fall first, else set beats clear
        bus(1, OSCSC_IRQ_FLAG_OFS, 32'h3);
        bus(0, OSCSC_IRQ_FLAG_OFS, 0);
        `CHK("flagclr", 2'h0, rv[1:0])
        dh <= 1'b1;
        cyc(3);
        bus(1, OSCSC_XCTRL_OFS, 32'h0000_0080);
        bus(0, OSCSC_XCTRL_OFS, 0);
        cyc(2);
        `CHK("halted", {32'h0000_0080, 1'b0}, {rv, run})
        dh <= 1'b0;
        xd <= 1'b1;
        cyc(3);
        bus(1, OSCSC_XCTRL_OFS, 32'h0000_3006);
        bus(0, OSCSC_XCTRL_OFS, 0);
        `CHK("extdbg", 32'h0000_3006, rv)
        xd <= 1'b0;
        wp <= 1'b0;
        cp <= 1'b1;
        cyc(5);
        `CHK("cold", 1'b0, bre)
        cp <= 1'b0;
        cyc(5);
        `CHK("hot", 1'b1, bre)
        $display("t_protect done");
    endtask
    // Reset, then the scenarios in order
    initial begin
        {reset, rd, wr, wp, dh, xd, cp, req, bev} = 9'h100;
        adr = 4'h0;
        wd = 32'h0;
        slp = OSCSC_SLP_ACTIVE;
        error_cnt = 0;
        n_compared = 0;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        t_reset();
        t_modes();
        t_startup();
        t_protect();
        test_done();
    end
endmodule
`default_nettype wire
